// file: hw/nafu_alu.sv
`timescale 1ns/1ns
module nafu_alu #(
  parameter int W = 4
) (
  // operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  input wire nafu_pkg::nafu_op_t op,
  // answer
  output logic [W-1:0] result,
  output logic carry,
  output logic zero,
  output logic bcond
);
  import nafu_pkg::*;

  logic [W:0] sum;

  // one adder serves both directions; subtraction adds the inverted operand
  always_comb begin
    sum = '0;
    result = a;
    carry = cin;
    bcond = 1'b1;
    case (op)
      NAFU_LOAD_OP: begin
        result = b;
        bcond = ~(b == '0);
      end
      NAFU_ADD_OP, NAFU_ADD_WITH_CARRY_OP: begin
        sum = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        result = sum[W-1:0];
        carry = sum[W];
        bcond = ~sum[W];
      end
      NAFU_SUB_OP, NAFU_SUBTRACT_WITH_CARRY_OP: begin
        sum = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, cin};
        result = sum[W-1:0];
        carry = sum[W];
        bcond = sum[W]; // cleared on borrow
      end
      NAFU_AND_OP: begin
        result = a & b;
        bcond = ~((a & b) == '0);
      end
      NAFU_OR_OP: begin
        result = a | b;
        bcond = ~((a | b) == '0);
      end
      NAFU_XOR_OP: begin
        result = a ^ b;
        bcond = ~((a ^ b) == '0);
      end
      NAFU_ROTL_OP: begin
        result = {a[W-2:0], cin};
        carry = a[W-1];
      end
      NAFU_ROTR_OP: begin
        result = {cin, a[W-1:1]};
        carry = a[0];
      end
      default: begin
        result = a;
      end
    endcase
    zero = (result == '0);
  end

endmodule

// file: hw/nafu_pkg.sv
package nafu_pkg;

  // datapath and bus widths
  localparam int NAFU_W = 4;
  localparam int NAFU_AXI_ADDR_W = 8;
  localparam int NAFU_AXI_DATA_W = 32;
  localparam int NAFU_OPCOUNT_W = 16;

  // register byte offsets
  localparam logic [7:0] NAFU_WORK_OFFS = 8'h00;
  localparam logic [7:0] NAFU_FLAGS_OFFS = 8'h04;
  localparam logic [7:0] NAFU_RESULT_OFFS = 8'h08;
  localparam logic [7:0] NAFU_CTRL_OFFS = 8'h0c;
  localparam logic [7:0] NAFU_OPCOUNT_OFFS = 8'h10;

  // flag register layout
  localparam int NAFU_FLAG_CARRY_POS = 3;
  localparam int NAFU_FLAG_ZERO_POS = 2;
  localparam int NAFU_FLAG_BRANCH_POS = 1;
  localparam int NAFU_FLAG_USER_POS = 0;

  // result register layout, bits [3:0] hold the result nibble
  localparam int NAFU_RES_CARRY_POS = 4;
  localparam int NAFU_RES_ZERO_POS = 5;
  localparam int NAFU_RES_TAKEN_POS = 6;

  // control register layout
  localparam int NAFU_CTRL_EXEC_EN_POS = 0;

  // reset values
  localparam logic [3:0] NAFU_WORK_RST = 4'h0;
  localparam logic NAFU_CARRY_RST = 1'b0;
  localparam logic NAFU_ZERO_RST = 1'b0;
  localparam logic NAFU_BRANCH_RST = 1'b1;
  localparam logic NAFU_USER_RST = 1'b0;
  localparam logic NAFU_EXEC_EN_RST = 1'b1;

  // bus responses
  localparam logic [1:0] NAFU_RESP_OKAY = 2'h0;
  localparam logic [1:0] NAFU_RESP_SLVERR = 2'h2;

  // operations chosen by the sequencer
  typedef enum logic [3:0] {
    NAFU_NOP,
    NAFU_LOAD_OP,
    NAFU_ADD_OP,
    NAFU_ADD_WITH_CARRY_OP,
    NAFU_SUB_OP,
    NAFU_SUBTRACT_WITH_CARRY_OP,
    NAFU_AND_OP,
    NAFU_OR_OP,
    NAFU_XOR_OP,
    NAFU_ROTL_OP,
    NAFU_ROTR_OP,
    NAFU_SET_USER_OP,
    NAFU_CLR_USER_OP,
    NAFU_TEST_USER_OP,
    NAFU_BRANCH_OP,
    NAFU_RETURN_FROM_INTERRUPT_OP
  } nafu_op_t;

endpackage

// file: hw/nafu_top.sv
`timescale 1ns/1ns
// Functional notes
// - ALU performs selected 4-bit operation, giving result, carry and zero.
// - work register is one source operand and receives the result.
// - addition carry is the carry out of the top sum bit.
// - subtraction adds two's complement; carry one means no borrow.
// - zero detect is one when all four result or moved bits are zero.
// - four flags pushed on interrupt accept, restored by interrupt return.
// - carry bit captures add carry and feeds add-with-carry as carry in.
// - carry bit holds non-borrow and feeds subtract-with-carry as carry in.
// - rotates load carry bit with the bit shifted out.
// - zero bit takes zero detect when the operation asks for it.
// - branch condition bit set or cleared by each operation, normally one.
// - branch taken only while branch condition bit is one.
// - branch condition bit is one after initialization.
// - after the flag push on interrupt accept, branch condition forced one.
// - user bit is plain general purpose: set, clear, test.
module nafu_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // operation request from the sequencer
  input wire logic OP_VALID,
  input wire nafu_pkg::nafu_op_t OP_CODE,
  input wire logic [nafu_pkg::NAFU_W-1:0] OP_OPERAND,
  input wire logic OP_UPD_CARRY,
  input wire logic OP_UPD_ZERO,
  // interrupt acceptance
  input wire logic INT_ACCEPT,
  // operation answer
  output logic OP_DONE,
  output logic [nafu_pkg::NAFU_W-1:0] RESULT,
  output logic CARRY_OUT,
  output logic ZERO_OUT,
  output logic BRANCH_TAKEN,
  output logic [nafu_pkg::NAFU_W-1:0] WORK,
  output logic [nafu_pkg::NAFU_W-1:0] FLAGS,
  // flag image for the stack
  output logic FLAG_SAVE_VALID,
  output logic [nafu_pkg::NAFU_W-1:0] FLAG_SAVE,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [nafu_pkg::NAFU_AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [nafu_pkg::NAFU_AXI_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [nafu_pkg::NAFU_AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [nafu_pkg::NAFU_AXI_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);
  import nafu_pkg::*;

  logic [NAFU_W-1:0] work_reg;
  logic carry_bit_reg;
  logic zero_bit_reg;
  logic branch_condition_bit_reg;
  logic user_bit_reg;
  logic exec_en_reg;
  logic [NAFU_OPCOUNT_W-1:0] opcount_reg;
  logic [NAFU_W-1:0] flags_vec;
  logic accept;
  logic alu_cin;
  logic [NAFU_W-1:0] alu_result;
  logic alu_carry;
  logic alu_zero;
  logic alu_bcond;
  logic writes_work;
  logic is_arith;
  logic is_rotate;
  logic aw_full_reg;
  logic w_full_reg;
  logic [NAFU_AXI_ADDR_W-1:0] aw_addr_reg;
  logic [NAFU_AXI_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_hit;
  logic bus_wr_work;
  logic bus_wr_flags;
  logic bus_wr_ctrl;
  logic [NAFU_AXI_DATA_W-1:0] rd_next;
  logic rd_hit;

  // the interrupt owns the flags in its cycle, so a coincident operation is dropped
  assign accept = OP_VALID && exec_en_reg && !INT_ACCEPT;
  assign flags_vec = {carry_bit_reg, zero_bit_reg, branch_condition_bit_reg, user_bit_reg};

  // operation classes
  assign is_arith = (OP_CODE == NAFU_ADD_OP) || (OP_CODE == NAFU_ADD_WITH_CARRY_OP) ||
                    (OP_CODE == NAFU_SUB_OP) || (OP_CODE == NAFU_SUBTRACT_WITH_CARRY_OP);
  assign is_rotate = (OP_CODE == NAFU_ROTL_OP) || (OP_CODE == NAFU_ROTR_OP);
  assign writes_work = is_arith || is_rotate || (OP_CODE == NAFU_LOAD_OP) || (OP_CODE == NAFU_AND_OP) ||
                       (OP_CODE == NAFU_OR_OP) || (OP_CODE == NAFU_XOR_OP);

  // carry in: stored carry for the with-carry ops and rotates, fixed for plain ones
  always_comb begin
    case (OP_CODE)
      NAFU_ADD_OP: alu_cin = 1'b0;
      NAFU_SUB_OP: alu_cin = 1'b1;
      NAFU_ADD_WITH_CARRY_OP: alu_cin = carry_bit_reg;
      NAFU_SUBTRACT_WITH_CARRY_OP: alu_cin = carry_bit_reg;
      default: alu_cin = carry_bit_reg;
    endcase
  end

  // the work register is always the first operand
  nafu_alu #(.W(NAFU_W)) u_alu (
    .a(work_reg),
    .b(OP_OPERAND),
    .cin(alu_cin),
    .op(OP_CODE),
    .result(alu_result),
    .carry(alu_carry),
    .zero(alu_zero),
    .bcond(alu_bcond)
  );

  // work register: operation result first, bus write only in a quiet cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      work_reg <= NAFU_WORK_RST;
    end else if (accept && writes_work) begin
      work_reg <= alu_result;
    end else if (bus_wr_work && !accept && !INT_ACCEPT) begin
      work_reg <= w_data_reg[NAFU_W-1:0];
    end
  end

  // carry and zero bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      carry_bit_reg <= NAFU_CARRY_RST;
      zero_bit_reg <= NAFU_ZERO_RST;
    end else if (INT_ACCEPT) begin
      carry_bit_reg <= carry_bit_reg;
    end else if (accept) begin
      if (OP_CODE == NAFU_RETURN_FROM_INTERRUPT_OP) begin
        carry_bit_reg <= OP_OPERAND[NAFU_FLAG_CARRY_POS];
        zero_bit_reg <= OP_OPERAND[NAFU_FLAG_ZERO_POS];
      end else begin
        if (is_rotate || (is_arith && OP_UPD_CARRY)) begin
          carry_bit_reg <= alu_carry;
        end
        if (writes_work && OP_UPD_ZERO) begin
          zero_bit_reg <= alu_zero;
        end
      end
    end else if (bus_wr_flags) begin
      carry_bit_reg <= w_data_reg[NAFU_FLAG_CARRY_POS];
      zero_bit_reg <= w_data_reg[NAFU_FLAG_ZERO_POS];
    end
  end

  // branch condition and user bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      branch_condition_bit_reg <= NAFU_BRANCH_RST;
      user_bit_reg <= NAFU_USER_RST;
    end else if (INT_ACCEPT) begin
      branch_condition_bit_reg <= 1'b1;
    end else if (accept) begin
      case (OP_CODE)
        NAFU_RETURN_FROM_INTERRUPT_OP: begin
          branch_condition_bit_reg <= OP_OPERAND[NAFU_FLAG_BRANCH_POS];
          user_bit_reg <= OP_OPERAND[NAFU_FLAG_USER_POS];
        end
        NAFU_SET_USER_OP: begin
          user_bit_reg <= 1'b1;
          branch_condition_bit_reg <= 1'b1;
        end
        NAFU_CLR_USER_OP: begin
          user_bit_reg <= 1'b0;
          branch_condition_bit_reg <= 1'b1;
        end
        NAFU_TEST_USER_OP: branch_condition_bit_reg <= user_bit_reg;
        default: branch_condition_bit_reg <= alu_bcond;
      endcase
    end else if (bus_wr_flags) begin
      branch_condition_bit_reg <= w_data_reg[NAFU_FLAG_BRANCH_POS];
      user_bit_reg <= w_data_reg[NAFU_FLAG_USER_POS];
    end
  end

  // answer to the sequencer, one cycle after the request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OP_DONE <= 1'b0;
      BRANCH_TAKEN <= 1'b0;
      RESULT <= '0;
      CARRY_OUT <= 1'b0;
      ZERO_OUT <= 1'b0;
    end else begin
      OP_DONE <= accept;
      BRANCH_TAKEN <= accept && (OP_CODE == NAFU_BRANCH_OP) && branch_condition_bit_reg;
      if (accept && writes_work) begin
        RESULT <= alu_result;
        CARRY_OUT <= alu_carry;
        ZERO_OUT <= alu_zero;
      end
    end
  end

  // flag image offered to the stack on interrupt acceptance
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FLAG_SAVE_VALID <= 1'b0;
      FLAG_SAVE <= '0;
    end else begin
      FLAG_SAVE_VALID <= INT_ACCEPT;
      if (INT_ACCEPT) begin
        FLAG_SAVE <= flags_vec;
      end
    end
  end

  // mirrors of the architectural state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WORK <= NAFU_WORK_RST;
      FLAGS <= {NAFU_CARRY_RST, NAFU_ZERO_RST, NAFU_BRANCH_RST, NAFU_USER_RST};
    end else begin
      WORK <= work_reg;
      FLAGS <= flags_vec;
    end
  end

  // control and counter; the counter wraps, software compares differences
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      exec_en_reg <= NAFU_EXEC_EN_RST;
      opcount_reg <= '0;
    end else begin
      if (bus_wr_ctrl) begin
        exec_en_reg <= w_data_reg[NAFU_CTRL_EXEC_EN_POS];
      end
      if (accept) begin
        opcount_reg <= opcount_reg + {{(NAFU_OPCOUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // write decode; only the low byte lane carries register bits
  assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID;
  assign bus_wr_work = wr_fire && w_strb_reg[0] && (aw_addr_reg == NAFU_WORK_OFFS);
  assign bus_wr_flags = wr_fire && w_strb_reg[0] && (aw_addr_reg == NAFU_FLAGS_OFFS);
  assign bus_wr_ctrl = wr_fire && w_strb_reg[0] && (aw_addr_reg == NAFU_CTRL_OFFS);
  assign wr_hit = (aw_addr_reg == NAFU_WORK_OFFS) || (aw_addr_reg == NAFU_FLAGS_OFFS) ||
                  (aw_addr_reg == NAFU_CTRL_OFFS);

  // write channels: address and data held independently until the response
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= NAFU_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[NAFU_AXI_ADDR_W-1:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? NAFU_RESP_OKAY : NAFU_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    rd_next = '0;
    rd_hit = 1'b1;
    case ({S_AXI_ARADDR[NAFU_AXI_ADDR_W-1:2], 2'h0})
      NAFU_WORK_OFFS: rd_next[NAFU_W-1:0] = work_reg;
      NAFU_FLAGS_OFFS: rd_next[NAFU_W-1:0] = flags_vec;
      NAFU_RESULT_OFFS: begin
        rd_next[NAFU_W-1:0] = RESULT;
        rd_next[NAFU_RES_CARRY_POS] = CARRY_OUT;
        rd_next[NAFU_RES_ZERO_POS] = ZERO_OUT;
        rd_next[NAFU_RES_TAKEN_POS] = BRANCH_TAKEN;
      end
      NAFU_CTRL_OFFS: rd_next[NAFU_CTRL_EXEC_EN_POS] = exec_en_reg;
      NAFU_OPCOUNT_OFFS: rd_next[NAFU_OPCOUNT_W-1:0] = opcount_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one read in flight, data captured at the address handshake
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= NAFU_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_next;
      S_AXI_RRESP <= rd_hit ? NAFU_RESP_OKAY : NAFU_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  a_add_carry: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_ADD_OP) |=>
      {CARRY_OUT, RESULT} == ({1'b0, $past(work_reg)} + {1'b0, $past(OP_OPERAND)}))
    else $error("add result or carry wrong");

  a_sub_borrow: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_SUB_OP) |=>
      (CARRY_OUT == ($past(work_reg) >= $past(OP_OPERAND))) && (RESULT == $past(work_reg) - $past(OP_OPERAND)))
    else $error("subtract carry is not the non-borrow");

  a_zero_detect: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && writes_work |=> ZERO_OUT == (RESULT == '0))
    else $error("zero detect disagrees with result");

  a_work_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && writes_work |=> work_reg == RESULT)
    else $error("work register missed the result");

  a_addc_cin: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_ADD_WITH_CARRY_OP) && OP_UPD_CARRY |=>
      {carry_bit_reg, RESULT} == ({1'b0, $past(work_reg)} + {1'b0, $past(OP_OPERAND)} + {4'h0, $past(carry_bit_reg)}))
    else $error("add with carry did not use stored carry");

  a_subc_cin: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_SUBTRACT_WITH_CARRY_OP) && OP_UPD_CARRY |=>
      {carry_bit_reg, RESULT} == ({1'b0, $past(work_reg)} + {1'b0, ~$past(OP_OPERAND)} + {4'h0, $past(carry_bit_reg)}))
    else $error("subtract with carry did not use stored carry");

  a_rotate_carry: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_ROTL_OP) |=> (carry_bit_reg == $past(work_reg[3])) && (work_reg[0] == $past(carry_bit_reg)))
    else $error("rotate left lost the shifted bit");

  a_zero_update: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && writes_work && OP_UPD_ZERO |=> zero_bit_reg == (work_reg == '0))
    else $error("zero bit not taken from result");

  a_flags_keep: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && !is_rotate && !OP_UPD_CARRY && !OP_UPD_ZERO && (OP_CODE != NAFU_RETURN_FROM_INTERRUPT_OP) |=>
      $stable(carry_bit_reg) && $stable(zero_bit_reg))
    else $error("carry or zero changed without an update");

  a_int_push: assert property (@(posedge CLK) disable iff (!RESET_N)
    INT_ACCEPT |=> FLAG_SAVE_VALID && (FLAG_SAVE == $past(flags_vec)) && branch_condition_bit_reg ##1 !FLAG_SAVE_VALID || $past(INT_ACCEPT, 1))
    else $error("interrupt push or branch force wrong");

  a_int_restore: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_RETURN_FROM_INTERRUPT_OP) |=> flags_vec == $past(OP_OPERAND))
    else $error("flags not restored on interrupt return");

  a_branch_take: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept && (OP_CODE == NAFU_BRANCH_OP) |=> BRANCH_TAKEN == $past(branch_condition_bit_reg))
    else $error("branch taken does not follow the condition bit");

endmodule

// file: tb/nafu_seq_model.sv
`timescale 1ns/1ns
module nafu_seq_model (
  // clock
  input wire logic clk,
  // operation request
  output logic op_valid,
  output nafu_pkg::nafu_op_t op_code,
  output logic [3:0] op_operand,
  output logic op_upd_carry,
  output logic op_upd_zero,
  // interrupt acceptance
  output logic int_accept
);
  import nafu_pkg::*;

  // idle at time zero so nothing is taken during reset
  initial begin
    op_valid = 1'b0;
    op_code = NAFU_NOP;
    op_operand = 4'h0;
    op_upd_carry = 1'b0;
    op_upd_zero = 1'b0;
    int_accept = 1'b0;
  end

  // one request held for exactly one edge, the operand scrambled afterwards
  task automatic issue(input nafu_op_t op, input logic [3:0] opnd, input logic uc, input logic uz);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_operand <= opnd;
    op_upd_carry <= uc;
    op_upd_zero <= uz;
    @(posedge clk);
    op_valid <= 1'b0;
    op_operand <= ~opnd; // a stale operand must never look valid
  endtask

  // one-cycle interrupt acceptance pulse
  task automatic irq;
    @(posedge clk);
    int_accept <= 1'b1;
    @(posedge clk);
    int_accept <= 1'b0;
  endtask
endmodule

// file: tb/nafu_top_tb.sv
`timescale 1ns/1ns
module nafu_top_tb;
  import nafu_pkg::*;
  logic clk, reset_n, op_valid, upd_c, upd_z, int_acc, op_done, res_c, res_z, br_taken, fsave_v, last_bt;
  nafu_op_t op_code;
  logic [3:0] op_operand, result, work, flags, fsave;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int err_count = 0;
  int n_checks = 0;

  nafu_seq_model seq_u (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand),
    .op_upd_carry(upd_c), .op_upd_zero(upd_z), .int_accept(int_acc));

  nafu_top dut_u (.CLK(clk), .RESET_N(reset_n), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_OPERAND(op_operand), .OP_UPD_CARRY(upd_c), .OP_UPD_ZERO(upd_z), .INT_ACCEPT(int_acc),
    .OP_DONE(op_done), .RESULT(result), .CARRY_OUT(res_c), .ZERO_OUT(res_z), .BRANCH_TAKEN(br_taken),
    .WORK(work), .FLAGS(flags), .FLAG_SAVE_VALID(fsave_v), .FLAG_SAVE(fsave),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // wide enough that a response code joined to a data word is compared whole
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one operation, then one more edge so the delayed WORK and FLAGS copies settle
  task automatic op(input nafu_op_t code, input logic [3:0] b, input logic uc, input logic uz);
    seq_u.issue(code, b, uc, uz);
    #1;
    chk(op_done, 1'b1);
    last_bt = br_taken;
    @(posedge clk);
    #1;
  endtask

  // write address and data offered together; bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bready && bvalid));
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rready && rvalid));
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_reset;
    chk({work, flags}, 8'h02);
    axi_rd(NAFU_FLAGS_OFFS, d, r);
    chk({r, d}, {NAFU_RESP_OKAY, 32'h2});
    $display("reset test done");
  endtask

  // table entries: operand a, operand b, result, {subtract, carry, zero, 0}
  task automatic t_arith;
    logic [15:0] tbl [5];
    logic [3:0] e;
    tbl = '{16'h4590, 16'h7906, 16'h312c, 16'h220e, 16'h68e8};
    for (int i = 0; i < 5; i++) begin
      e = tbl[i][3:0];
      op(NAFU_LOAD_OP, tbl[i][15:12], 1'b0, 1'b0);
      op(e[3] ? NAFU_SUB_OP : NAFU_ADD_OP, tbl[i][11:8], 1'b1, 1'b1);
      chk({result, res_c, res_z}, {tbl[i][7:4], e[2], e[1]});
      chk(work, tbl[i][7:4]);
      chk(flags[3:1], {e[2], e[1], e[3] ~^ e[2]});
    end
    $display("arith test done");
  endtask

  task automatic t_carry;
    op(NAFU_LOAD_OP, 4'h2, 1'b0, 1'b0);
    op(NAFU_ADD_OP, 4'hf, 1'b1, 1'b0);
    op(NAFU_LOAD_OP, 4'h2, 1'b0, 1'b0);
    op(NAFU_ADD_WITH_CARRY_OP, 4'h3, 1'b1, 1'b0);
    chk({result, flags[3]}, {4'h6, 1'b0});
    op(NAFU_LOAD_OP, 4'h5, 1'b0, 1'b0);
    op(NAFU_SUBTRACT_WITH_CARRY_OP, 4'h2, 1'b1, 1'b0);
    chk({result, flags[3]}, {4'h2, 1'b1});
    op(NAFU_LOAD_OP, 4'h6, 1'b0, 1'b0);
    op(NAFU_ROTR_OP, 4'h0, 1'b0, 1'b0);
    chk({result, flags[3]}, {4'hb, 1'b0});
    op(NAFU_ROTL_OP, 4'h0, 1'b0, 1'b0);
    chk({result, flags[3]}, {4'h6, 1'b1});
    op(NAFU_LOAD_OP, 4'h0, 1'b0, 1'b1);
    op(NAFU_ADD_OP, 4'h1, 1'b0, 1'b0);
    chk(flags[3:2], 2'b11);
    $display("carry test done");
  endtask

  task automatic t_branch;
    // logic ops clear the branch bit only on a zero result
    op(NAFU_LOAD_OP, 4'hc, 1'b0, 1'b0);
    op(NAFU_AND_OP, 4'ha, 1'b0, 1'b1);
    chk({result, flags[2:1]}, {4'h8, 2'b01});
    op(NAFU_OR_OP, 4'h3, 1'b0, 1'b1);
    chk({result, flags[2:1]}, {4'hb, 2'b01});
    op(NAFU_XOR_OP, 4'hb, 1'b0, 1'b1);
    chk({result, res_z, flags[2:1]}, {4'h0, 3'b110});
    op(NAFU_LOAD_OP, 4'h7, 1'b0, 1'b0);
    op(NAFU_ADD_OP, 4'h9, 1'b1, 1'b1);
    op(NAFU_BRANCH_OP, 4'h0, 1'b0, 1'b0);
    chk(last_bt, 1'b0);
    op(NAFU_BRANCH_OP, 4'h0, 1'b0, 1'b0);
    chk(last_bt, 1'b1);
    $display("branch test done");
  endtask

  task automatic t_int;
    op(NAFU_CLR_USER_OP, 4'h0, 1'b0, 1'b0);
    op(NAFU_TEST_USER_OP, 4'h0, 1'b0, 1'b0);
    chk(flags[1:0], 2'b00);
    op(NAFU_SET_USER_OP, 4'h0, 1'b0, 1'b0);
    op(NAFU_TEST_USER_OP, 4'h0, 1'b0, 1'b0);
    chk(flags[1:0], 2'b11);
    op(NAFU_LOAD_OP, 4'hf, 1'b0, 1'b0);
    op(NAFU_ADD_OP, 4'h1, 1'b1, 1'b1);
    seq_u.irq;
    #1;
    chk({fsave_v, fsave}, 5'h1d);
    @(posedge clk);
    #1;
    chk(flags, 4'hf);
    op(NAFU_RETURN_FROM_INTERRUPT_OP, 4'h5, 1'b0, 1'b0);
    chk(flags, 4'h5);
    $display("interrupt test done");
  endtask

  task automatic t_bus;
    axi_wr(NAFU_WORK_OFFS, 32'ha, r);
    @(posedge clk);
    #1;
    chk({r, work}, {NAFU_RESP_OKAY, 4'ha});
    op(NAFU_ADD_OP, 4'h1, 1'b0, 1'b0);
    chk(result, 4'hb);
    axi_rd(NAFU_RESULT_OFFS, d, r);
    chk({r, d}, {NAFU_RESP_OKAY, 32'hb});
    axi_rd(8'h14, d, r);
    chk({r, d}, {NAFU_RESP_SLVERR, 32'h0});
    axi_wr(NAFU_CTRL_OFFS, 32'h0, r);
    seq_u.issue(NAFU_LOAD_OP, 4'h3, 1'b0, 1'b0);
    #1;
    chk(op_done, 1'b0);
    axi_wr(NAFU_CTRL_OFFS, 32'h1, r);
    $display("bus test done");
  endtask

  // a hung handshake must still end the run
  initial begin
    #1000000;
    err_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test;
  end

  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    t_reset;
    t_arith;
    t_carry;
    t_branch;
    t_int;
    t_bus;
    end_of_test;
  end
endmodule
